// file: src/xalu_cfg.svh
// offsets, field positions, reset values and cycle counts of the extended alu
`ifndef XALU_CFG_SVH
`define XALU_CFG_SVH
// ****************************************
// register byte offsets
// ****************************************
`define XALU_OFF_CMD   12'h000
`define XALU_OFF_ADDR  12'h004
`define XALU_OFF_ACC   12'h008
`define XALU_OFF_FLAGS 12'h00c
`define XALU_OFF_STAT  12'h010
`define XALU_OFF_MADDR 12'h014
`define XALU_OFF_MDATA 12'h018
// ****************************************
// fields
// ****************************************
`define XALU_CMD_OP_LO  0
`define XALU_CMD_BIT_LO 5
`define XALU_FLG_W      6
`define XALU_FLG_C      0
`define XALU_FLG_Z      1
`define XALU_FLG_AC     2
`define XALU_FLG_OV     3
`define XALU_FLG_SC     4
`define XALU_FLG_CZ     5
`define XALU_ST_BUSY    0
`define XALU_ST_SKIP    1
`define XALU_ST_SQUASH  2
`define XALU_ST_CYC_LO  4
// ****************************************
// reset values and constants
// ****************************************
`define XALU_ACC_RST   8'h00
`define XALU_FLG_RST   6'h00
`define XALU_CMD_RST   8'h00
`define XALU_ONES      8'hff
`define XALU_ZERO      8'h00
`define XALU_CYC_NONE  2'h0
`define XALU_CYC_PLAIN 2'h1
`define XALU_CYC_SKIP  2'h2
`endif

// file: src/xalu_pkg.sv
// types of the extended alu
package xalu_pkg;
   typedef enum logic [4:0] {
      ext_or_into_accum                   = 5'h00,
      ext_or_into_memory                  = 5'h01,
      ext_rotate_left                     = 5'h02,
      ext_rotate_left_to_accum            = 5'h03,
      ext_rotate_left_thru_wrap           = 5'h04,
      ext_rotate_left_thru_wrap_to_accum  = 5'h05,
      ext_rotate_right                    = 5'h06,
      ext_rotate_right_to_accum           = 5'h07,
      ext_rotate_right_thru_wrap          = 5'h08,
      ext_rotate_right_thru_wrap_to_accum = 5'h09,
      ext_subtract_borrow                 = 5'h0a,
      ext_subtract_borrow_to_memory       = 5'h0b,
      ext_subtract                        = 5'h0c,
      ext_subtract_to_memory              = 5'h0d,
      ext_decrement_skip                  = 5'h0e,
      ext_decrement_skip_to_accum         = 5'h0f,
      ext_increment_skip                  = 5'h10,
      ext_increment_skip_to_accum         = 5'h11,
      ext_set_ones                        = 5'h12,
      ext_set_one_bit                     = 5'h13,
      ext_skip_nonzero                    = 5'h14,
      ext_skip_bit_nonzero                = 5'h15,
      ext_nibble_exchange                 = 5'h16,
      ext_nibble_exchange_to_accum        = 5'h17
   } xalu_op_t;
   typedef enum logic [1:0] {
      xalu_st_idle  = 2'b00,
      xalu_st_fetch = 2'b01,
      xalu_st_exec  = 2'b11,
      xalu_st_dummy = 2'b10
   } xalu_state_t;
endpackage

// file: src/xalu_mem.sv
// flat data memory, registered read data
`timescale 1ns/100ps
module xalu_mem #(
   parameter int AW = 12
) (
   input  wire logic          clk,
   input  wire logic [AW-1:0] raddr,
   output logic [7:0]         rdata,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [7:0]    wdata
);
   logic [7:0] mem [0:(1<<AW)-1];

   // no reset on the array; contents are undefined until written
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      rdata <= mem[raddr];
   end
endmodule

// file: src/xalu_core.sv
// extended alu datapath: or, rotates, subtracts, skips, set and swap
`timescale 1ns/100ps
`include "xalu_cfg.svh"
//
// Behaviour
// RULE1: or accumulator with memory byte; result to acc or memory; only zero flag.
// RULE2: rotate left, bit 7 into bit 0; to memory or acc; no flags.
// RULE3: rotate left through carry; old carry to bit 0, bit 7 to carry.
// RULE4: rotate right, bit 0 into bit 7; to memory or acc; no flags.
// RULE5: rotate right through carry; old carry to bit 7, bit 0 to carry.
// RULE6: acc minus byte minus not carry; six arithmetic flags updated.
// RULE7: subtraction carry is cleared when negative, set when zero or positive.
// RULE8: acc minus byte without carry in; same six flags.
// RULE9: decrement byte in place; skip next when new value is zero.
// RULE10: acc gets byte minus one; memory kept; skip when zero.
// RULE11: increment byte in place; skip next when new value is zero.
// RULE12: acc gets byte plus one; memory kept; skip when zero.
// RULE13: a skipping instruction inserts a dummy cycle, taking two cycles.
// RULE14: set all bits of the byte to one; flags kept.
// RULE15: set one selected bit of the byte; other bits and flags kept.
// RULE16: skip next when byte is nonzero; memory and flags kept.
// RULE17: skip next when selected bit is one; memory and flags kept.
// RULE18: swap nibbles, in place or into acc; flags kept.
// RULE19: every operation reaches the whole data memory directly.
// RULE20: skip squashes the next instruction to a no-op; others take one cycle.
// RULE21: arithmetic flags follow the core status definitions.
//
module xalu_core #(
   parameter int AW = 12
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   // ****************************************
   // state
   // ****************************************
   xalu_pkg::xalu_state_t        state_r;
   xalu_pkg::xalu_op_t           op_r;
   logic [2:0]                   bit_r;
   logic [AW-1:0]                addr_r;
   logic [AW-1:0]                maddr_r;
   logic [7:0]                   acc_r;
   logic [`XALU_FLG_W-1:0]       flags_r;
   logic                         skip_pend_r;
   logic                         squash_r;
   logic [1:0]                   cyc_r;
   logic                         rd_wait_r;
   logic [31:0]                  prdata_r;
   logic [7:0]                   mem_q;
   logic                         mem_we;
   logic [AW-1:0]                mem_wa;
   logic [7:0]                   mem_wd;
   logic [AW-1:0]                mem_ra;
   // datapath results
   logic [7:0]                   res;
   logic                         res_to_mem;
   logic                         res_to_acc;
   logic                         skip;
   logic [`XALU_FLG_W-1:0]       flg_nxt;
   logic [9:0]                   dif;
   logic                         cin;
   logic                         arith;
   logic                         rd_sel;
   logic [31:0]                  rd_mux;
   logic                         acc_fire;
   logic                         wr_fire;
   logic                         idle;
   logic                         mapped;

   // ****************************************
   // functions
   // ****************************************
   // {nibble carry, carry, result} of a + ~b + ci
   function automatic logic [9:0] sub_f(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic       ci);
      logic [8:0] s;
      logic [4:0] n;
      s = {1'b0, a} + {1'b0, ~b} + {8'h00, ci};
      n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ci};
      sub_f = {n[4], s[8], s[7:0]};
   endfunction

   function automatic logic reg_hit(input logic [11:0] a);
      reg_hit = (a == `XALU_OFF_CMD)   || (a == `XALU_OFF_ADDR)  ||
                (a == `XALU_OFF_ACC)   || (a == `XALU_OFF_FLAGS) ||
                (a == `XALU_OFF_STAT)  || (a == `XALU_OFF_MADDR) ||
                (a == `XALU_OFF_MDATA);
   endfunction

   // ****************************************
   // apb slave
   // ****************************************
   assign idle     = (state_r == xalu_pkg::xalu_st_idle);
   assign mapped   = reg_hit(paddr);
   // reads wait one cycle so memory data can come from its register
   assign acc_fire = psel && penable;
   assign pready   = idle && (pwrite || rd_wait_r);
   assign pslverr  = acc_fire && pready && !mapped;
   assign wr_fire  = acc_fire && pready && pwrite;
   assign prdata   = prdata_r;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `XALU_OFF_CMD:   rd_mux = {24'h00_0000, bit_r, op_r};
         `XALU_OFF_ADDR:  rd_mux = 32'(addr_r);
         `XALU_OFF_ACC:   rd_mux = {24'h00_0000, acc_r};
         `XALU_OFF_FLAGS: rd_mux = {26'h000_0000, flags_r};
         `XALU_OFF_STAT:  rd_mux = {26'h000_0000, cyc_r, 1'b0, squash_r,
                                    skip_pend_r, !idle};
         `XALU_OFF_MADDR: rd_mux = 32'(maddr_r);
         `XALU_OFF_MDATA: rd_mux = {24'h00_0000, mem_q};
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   assign rd_sel = acc_fire && !pwrite && idle && !rd_wait_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_wait_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         rd_wait_r <= rd_sel;
         if (rd_sel) begin
            prdata_r <= rd_mux;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r  <= '0;
         maddr_r <= '0;
      end else if (wr_fire) begin
         if (paddr == `XALU_OFF_ADDR) begin
            addr_r <= pwdata[AW-1:0];
         end
         if (paddr == `XALU_OFF_MADDR) begin
            maddr_r <= pwdata[AW-1:0];
         end
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r     <= xalu_pkg::xalu_st_idle;
         op_r        <= xalu_pkg::xalu_op_t'(`XALU_CMD_RST);
         bit_r       <= 3'h0;
         skip_pend_r <= 1'b0;
         squash_r    <= 1'b0;
         cyc_r       <= `XALU_CYC_NONE;
      end else begin
         case (state_r)
            xalu_pkg::xalu_st_idle: begin
               if (wr_fire && paddr == `XALU_OFF_CMD) begin
                  op_r  <= xalu_pkg::xalu_op_t'(pwdata[4:0]);
                  bit_r <= pwdata[7:5];
                  // RULE20: squash fetched instruction
                  if (skip_pend_r) begin
                     skip_pend_r <= 1'b0;
                     squash_r    <= 1'b1;
                  end else begin
                     squash_r <= 1'b0;
                     state_r  <= xalu_pkg::xalu_st_fetch;
                  end
               end
            end
            xalu_pkg::xalu_st_fetch: begin
               state_r <= xalu_pkg::xalu_st_exec;
            end
            xalu_pkg::xalu_st_exec: begin
               // RULE13: dummy cycle on skip
               if (skip) begin
                  skip_pend_r <= 1'b1;
                  cyc_r       <= `XALU_CYC_SKIP;
                  state_r     <= xalu_pkg::xalu_st_dummy;
               end else begin
                  cyc_r   <= `XALU_CYC_PLAIN;
                  state_r <= xalu_pkg::xalu_st_idle;
               end
            end
            xalu_pkg::xalu_st_dummy: begin
               state_r <= xalu_pkg::xalu_st_idle;
            end
            default: begin
               state_r <= xalu_pkg::xalu_st_idle;
            end
         endcase
      end
   end

   // ****************************************
   // datapath
   // ****************************************
   assign cin   = (op_r == xalu_pkg::ext_subtract_borrow ||
                   op_r == xalu_pkg::ext_subtract_borrow_to_memory) ?
                  flags_r[`XALU_FLG_C] : 1'b1;
   assign dif   = sub_f(acc_r, mem_q, cin);

   always_comb begin
      res        = mem_q;
      res_to_mem = 1'b0;
      res_to_acc = 1'b0;
      skip       = 1'b0;
      arith      = 1'b0;
      flg_nxt    = flags_r;
      case (op_r)
         // RULE1: or, zero flag only
         xalu_pkg::ext_or_into_accum,
         xalu_pkg::ext_or_into_memory: begin
            res                  = acc_r | mem_q;
            res_to_mem           = (op_r == xalu_pkg::ext_or_into_memory);
            res_to_acc           = !res_to_mem;
            flg_nxt[`XALU_FLG_Z] = (res == `XALU_ZERO);
         end
         // RULE2: plain rotate left
         xalu_pkg::ext_rotate_left,
         xalu_pkg::ext_rotate_left_to_accum: begin
            res        = {mem_q[6:0], mem_q[7]};
            res_to_mem = (op_r == xalu_pkg::ext_rotate_left);
            res_to_acc = !res_to_mem;
         end
         // RULE3: rotate left through carry
         xalu_pkg::ext_rotate_left_thru_wrap,
         xalu_pkg::ext_rotate_left_thru_wrap_to_accum: begin
            res                  = {mem_q[6:0], flags_r[`XALU_FLG_C]};
            res_to_mem           = (op_r == xalu_pkg::ext_rotate_left_thru_wrap);
            res_to_acc           = !res_to_mem;
            flg_nxt[`XALU_FLG_C] = mem_q[7];
         end
         // RULE4: plain rotate right
         xalu_pkg::ext_rotate_right,
         xalu_pkg::ext_rotate_right_to_accum: begin
            res        = {mem_q[0], mem_q[7:1]};
            res_to_mem = (op_r == xalu_pkg::ext_rotate_right);
            res_to_acc = !res_to_mem;
         end
         // RULE5: rotate right through carry
         xalu_pkg::ext_rotate_right_thru_wrap,
         xalu_pkg::ext_rotate_right_thru_wrap_to_accum: begin
            res                  = {flags_r[`XALU_FLG_C], mem_q[7:1]};
            res_to_mem           = (op_r == xalu_pkg::ext_rotate_right_thru_wrap);
            res_to_acc           = !res_to_mem;
            flg_nxt[`XALU_FLG_C] = mem_q[0];
         end
         // RULE6: subtract with borrow
         // RULE8: plain subtract
         xalu_pkg::ext_subtract_borrow,
         xalu_pkg::ext_subtract_borrow_to_memory,
         xalu_pkg::ext_subtract,
         xalu_pkg::ext_subtract_to_memory: begin
            res        = dif[7:0];
            arith      = 1'b1;
            res_to_mem = (op_r == xalu_pkg::ext_subtract_borrow_to_memory ||
                          op_r == xalu_pkg::ext_subtract_to_memory);
            res_to_acc = !res_to_mem;
         end
         // RULE9: decrement in place, skip on zero
         xalu_pkg::ext_decrement_skip: begin
            res        = mem_q - 8'h01;
            res_to_mem = 1'b1;
            skip       = (res == `XALU_ZERO);
         end
         // RULE10: decrement into acc, skip on zero
         xalu_pkg::ext_decrement_skip_to_accum: begin
            res        = mem_q - 8'h01;
            res_to_acc = 1'b1;
            skip       = (res == `XALU_ZERO);
         end
         // RULE11: increment in place, skip on zero
         xalu_pkg::ext_increment_skip: begin
            res        = mem_q + 8'h01;
            res_to_mem = 1'b1;
            skip       = (res == `XALU_ZERO);
         end
         // RULE12: increment into acc, skip on zero
         xalu_pkg::ext_increment_skip_to_accum: begin
            res        = mem_q + 8'h01;
            res_to_acc = 1'b1;
            skip       = (res == `XALU_ZERO);
         end
         // RULE14: all ones
         xalu_pkg::ext_set_ones: begin
            res        = `XALU_ONES;
            res_to_mem = 1'b1;
         end
         // RULE15: one bit forced high
         xalu_pkg::ext_set_one_bit: begin
            res        = mem_q | (8'h01 << bit_r);
            res_to_mem = 1'b1;
         end
         // RULE16: skip when byte nonzero
         xalu_pkg::ext_skip_nonzero: begin
            skip = (mem_q != `XALU_ZERO);
         end
         // RULE17: skip when bit set
         xalu_pkg::ext_skip_bit_nonzero: begin
            skip = mem_q[bit_r];
         end
         // RULE18: nibble swap
         xalu_pkg::ext_nibble_exchange,
         xalu_pkg::ext_nibble_exchange_to_accum: begin
            res        = {mem_q[3:0], mem_q[7:4]};
            res_to_mem = (op_r == xalu_pkg::ext_nibble_exchange);
            res_to_acc = !res_to_mem;
         end
         // unknown codes act as a no-op
         default: begin
            res = mem_q;
         end
      endcase
      // RULE21: core status flag definitions
      if (arith) begin
         // RULE7: carry is the inverted borrow
         flg_nxt[`XALU_FLG_C]  = dif[8];
         flg_nxt[`XALU_FLG_AC] = dif[9];
         flg_nxt[`XALU_FLG_Z]  = (dif[7:0] == `XALU_ZERO);
         flg_nxt[`XALU_FLG_OV] = (acc_r[7] ^ mem_q[7]) & (dif[7] ^ acc_r[7]);
         flg_nxt[`XALU_FLG_SC] = dif[7] ^ flg_nxt[`XALU_FLG_OV];
         flg_nxt[`XALU_FLG_CZ] = (op_r == xalu_pkg::ext_subtract ||
                                  op_r == xalu_pkg::ext_subtract_to_memory) ?
                                 flg_nxt[`XALU_FLG_Z] :
                                 (flg_nxt[`XALU_FLG_Z] & flags_r[`XALU_FLG_CZ]);
      end
   end

   // accumulator and flags, loaded by software only while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_r   <= `XALU_ACC_RST;
         flags_r <= `XALU_FLG_RST;
      end else if (state_r == xalu_pkg::xalu_st_exec) begin
         if (res_to_acc) begin
            acc_r <= res;
         end
         flags_r <= flg_nxt;
      end else if (wr_fire) begin
         if (paddr == `XALU_OFF_ACC) begin
            acc_r <= pwdata[7:0];
         end
         if (paddr == `XALU_OFF_FLAGS) begin
            flags_r <= pwdata[`XALU_FLG_W-1:0];
         end
      end
   end

   // ****************************************
   // memory port
   // ****************************************
   // RULE19: full address, no section select
   assign mem_ra = (state_r == xalu_pkg::xalu_st_fetch) ? addr_r : maddr_r;
   assign mem_we = ((state_r == xalu_pkg::xalu_st_exec) && res_to_mem) ||
                   (wr_fire && paddr == `XALU_OFF_MDATA);
   assign mem_wa = (state_r == xalu_pkg::xalu_st_exec) ? addr_r : maddr_r;
   assign mem_wd = (state_r == xalu_pkg::xalu_st_exec) ? res : pwdata[7:0];

   xalu_mem #(
      .AW (AW)
   ) u_mem (
      .clk   (pclk),
      .raddr (mem_ra),
      .rdata (mem_q),
      .we    (mem_we),
      .waddr (mem_wa),
      .wdata (mem_wd)
   );

   // ****************************************
   // checks
   // ****************************************
   or_accum_a: // RULE1
   assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == xalu_pkg::xalu_st_exec && op_r == xalu_pkg::ext_or_into_accum)
      |=> acc_r == ($past(acc_r) | $past(mem_q)) &&
          flags_r[`XALU_FLG_C] == $past(flags_r[`XALU_FLG_C]))
      else $error("or into acc wrong");

   rotate_left_a: // RULE2
   assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == xalu_pkg::xalu_st_exec && op_r == xalu_pkg::ext_rotate_left)
      |-> mem_we && mem_wd == {mem_q[6:0], mem_q[7]})
      else $error("rotate left wrong");

   rotate_carry_a: // RULE3
   assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == xalu_pkg::xalu_st_exec &&
       op_r == xalu_pkg::ext_rotate_left_thru_wrap_to_accum)
      |=> acc_r == {$past(mem_q[6:0]), $past(flags_r[`XALU_FLG_C])} &&
          flags_r[`XALU_FLG_C] == $past(mem_q[7]))
      else $error("rotate left through carry wrong");

   rotate_right_a: // RULE4
   assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == xalu_pkg::xalu_st_exec && op_r == xalu_pkg::ext_rotate_right_to_accum)
      |=> acc_r == {$past(mem_q[0]), $past(mem_q[7:1])} && $stable(flags_r))
      else $error("rotate right wrong");

   sub_carry_a: // RULE7
   assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == xalu_pkg::xalu_st_exec && op_r == xalu_pkg::ext_subtract)
      |=> flags_r[`XALU_FLG_C] == ($past(acc_r) >= $past(mem_q)) &&
          acc_r == 8'($past(acc_r) - $past(mem_q)))
      else $error("subtract carry wrong");

   sbc_memory_a: // RULE6
   assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == xalu_pkg::xalu_st_exec &&
       op_r == xalu_pkg::ext_subtract_borrow_to_memory)
      |-> mem_we && mem_wd == 8'(acc_r - mem_q - {7'h00, !flags_r[`XALU_FLG_C]}))
      else $error("subtract with borrow wrong");

   dec_skip_a: // RULE9
   assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == xalu_pkg::xalu_st_exec && op_r == xalu_pkg::ext_decrement_skip &&
       mem_q == 8'h01)
      |=> state_r == xalu_pkg::xalu_st_dummy && skip_pend_r ##1 idle)
      else $error("decrement skip wrong");

   set_ones_a: // RULE14
   assert property (@(posedge pclk) disable iff (!presetn)
      (state_r == xalu_pkg::xalu_st_exec && op_r == xalu_pkg::ext_set_ones)
      |-> mem_we && mem_wd == 8'hff)
      else $error("set ones wrong");

   squash_next_a: // RULE20
   assert property (@(posedge pclk) disable iff (!presetn)
      (idle && skip_pend_r && wr_fire && paddr == `XALU_OFF_CMD)
      |=> idle && !skip_pend_r && squash_r)
      else $error("skip did not squash");
endmodule

// file: verif/xalu_apb_master.sv
// apb requester standing in for the core decoder side
`timescale 1ns/100ps
module xalu_apb_master (
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // ****************************************
   // transfers
   // ****************************************
   // no wait count assumed; engine busy holds pready low, watchdog ends a hang
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// file: verif/xalu_core_tb.sv
// self-checking bench of the extended alu over apb
`timescale 1ns/100ps
`include "xalu_cfg.svh"
module xalu_core_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   int          fails, compares;
   logic [7:0]  tm [4] = '{8'h01, 8'h80, 8'hff, 8'h00};
   logic [7:0]  ta [4] = '{8'h02, 8'h7f, 8'h00, 8'h5a};
   logic [5:0]  tf [4] = '{6'h00, 6'h3f, 6'h01, 6'h21};
   logic [2:0]  tb [4] = '{3'h0, 3'h5, 3'h7, 3'h3};
   xalu_core #(.AW(12)) u_xalu_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr);
   xalu_apb_master u_xalu_apb_master (.pclk, .prdata, .pready, .pslverr, .psel,
      .penable, .pwrite, .paddr, .pwdata);
   initial pclk = 1'b0;
   always #12.5 pclk = ~pclk;
   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      u_xalu_apb_master.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      logic e;
      u_xalu_apb_master.xfer(1'b0, a, 32'h0, q, e);
   endtask
   // reference result: {skip, flags, acc, mem}
   function automatic logic [22:0] model(input logic [4:0] op, input logic [2:0] b,
                                         input logic [7:0] m, a, input logic [5:0] f);
      logic [7:0] r;
      logic [8:0] d;
      logic [4:0] n;
      logic [5:0] rf;
      logic       sk, v, bw, ci, to_acc;
      r = m;
      rf = f;
      sk = 1'b0;
      bw = (op < 5'h0c);
      ci = bw ? f[0] : 1'b1;
      to_acc = op inside {5'h00, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0a, 5'h0c, 5'h0f, 5'h11,
                          5'h17};
      case (op)
         5'h00, 5'h01: begin
            r = a | m;
            rf[1] = (r == 8'h00);
         end
         5'h02, 5'h03: r = {m[6:0], m[7]};
         5'h04, 5'h05: begin
            r = {m[6:0], f[0]};
            rf[0] = m[7];
         end
         5'h06, 5'h07: r = {m[0], m[7:1]};
         5'h08, 5'h09: begin
            r = {f[0], m[7:1]};
            rf[0] = m[0];
         end
         5'h0a, 5'h0b, 5'h0c, 5'h0d: begin
            d = {1'b0, a} + {1'b0, ~m} + ci;
            n = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + ci;
            r = d[7:0];
            v = (a[7] ^ m[7]) & (r[7] ^ a[7]);
            rf = {bw ? ((r == 8'h00) & f[5]) : (r == 8'h00), r[7] ^ v, v, n[4],
                  r == 8'h00, d[8]};
         end
         5'h0e, 5'h0f: begin
            r = m - 8'h01;
            sk = (r == 8'h00);
         end
         5'h10, 5'h11: begin
            r = m + 8'h01;
            sk = (r == 8'h00);
         end
         5'h12: r = 8'hff;
         5'h13: r[b] = 1'b1;
         5'h14: sk = (m != 8'h00);
         5'h15: sk = m[b];
         5'h16, 5'h17: r = {m[3:0], m[7:4]};
         default: r = m;
      endcase
      return {sk, rf, to_acc ? r : a, to_acc ? m : r};
   endfunction
   task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [7:0] m, a,
                      input logic [5:0] f);
      logic [22:0] e;
      logic [31:0] q;
      logic [11:0] ma;
      e = model(op, b, m, a, f);
      ma = {op, 7'h5a};
      wr(`XALU_OFF_MADDR, {20'h0, ma});
      wr(`XALU_OFF_MDATA, {24'h0, m});
      wr(`XALU_OFF_ACC, {24'h0, a});
      wr(`XALU_OFF_FLAGS, {26'h0, f});
      wr(`XALU_OFF_ADDR, {20'h0, ma});
      wr(`XALU_OFF_CMD, {24'h0, b, op});
      rd(`XALU_OFF_ACC, q);
      chk("acc", q[7:0], e[15:8]);
      rd(`XALU_OFF_FLAGS, q);
      chk("flags", q[5:0], e[21:16]);
      rd(`XALU_OFF_MDATA, q);
      chk("mem", q[7:0], e[7:0]);
      rd(`XALU_OFF_STAT, q);
      chk("stat", {q[5:4], q[2:0]}, {e[22] ? 2'h2 : 2'h1, 1'b0, e[22], 1'b0});
      if (e[22]) begin
         wr(`XALU_OFF_CMD, 32'h12);
         rd(`XALU_OFF_MDATA, q);
         chk("squashed mem", q[7:0], e[7:0]);
         rd(`XALU_OFF_STAT, q);
         chk("squash stat", q[2:1], 2'b10);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      logic [31:0] q;
      logic        e;
      presetn = 1'b0;
      fails = 0;
      compares = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(`XALU_OFF_ACC, q);
      chk("acc reset", q[7:0], `XALU_ACC_RST);
      u_xalu_apb_master.xfer(1'b0, 12'h01c, 32'h0, q, e);
      chk("unmapped err", {31'h0, e}, 32'h1);
      chk("unmapped data", q, 32'h0);
      for (int s = 0; s < 4; s++)
         for (int i = 0; i < 24; i++)
            run(5'(i), tb[s], tm[s], ta[s], tf[s]);
      conclude();
   end
   // whole run needs some 3400 cycles
   initial begin
      repeat (40000) @(posedge pclk);
      fails++;
      conclude();
   end
endmodule
